// file: cbr_regs.svh
`ifndef CBR_REGS_SVH
`define CBR_REGS_SVH
// register byte addresses
`define CBR_ADDR_CAL      32'hF804_80BC
`define CBR_ADDR_CTRL     32'hF804_80C0
`define CBR_ADDR_STAT     32'hF804_80C4
// calendar field positions
`define CBR_CENTURY_FIELD_LSB      0
`define CBR_YEAR_LSB      8
`define CBR_MONTH_LSB     16
`define CBR_DOW_LSB       21
`define CBR_DATE_LSB      24
// field limits in bcd
`define CBR_CENTURY_FIELD_GREG_LO  8'h19
`define CBR_CENTURY_FIELD_GREG_HI  8'h20
`define CBR_CENTURY_FIELD_PERS_LO  8'h13
`define CBR_CENTURY_FIELD_PERS_HI  8'h14
`define CBR_YEAR_MAX      8'h99
`define CBR_MONTH_MAX     8'h12
`define CBR_DOW_MAX       3'h7
`define CBR_DATE_MAX      8'h31
// reset value of calendar register: 2000, jan 1, day 1
`define CBR_CAL_RESET     32'h0121_0020
// control bits
`define CBR_CTRL_PERSIAN  0
`define CBR_CTRL_UTC      1
`define CBR_CTRL_RUN      2
// status bits
`define CBR_STAT_BADWR    0
`endif

// file: cbr_pkg.sv
`default_nettype none
package cbr_pkg;
  // one calendar snapshot, bcd fields
  typedef struct packed {
    logic [5:0] date;
    logic [2:0] dow;
    logic [4:0] month;
    logic [7:0] year;
    logic [7:0] century_field;
  } cbr_cal_t;
  // apb access phase
  typedef enum logic [0:0] {CBR_IDLE, CBR_ACCESS} cbr_bus_t;
endpackage : cbr_pkg
`default_nettype wire

// file: cbr_bcd_step.sv
`timescale 1ns/1ps
`default_nettype none
// one-digit-pair bcd increment with wrap to a low value
module cbr_bcd_step (
  input  wire logic [7:0] valueIn,
  input  wire logic [7:0] maxVal,
  input  wire logic [7:0] minVal,
  output logic      [7:0] valueOut,
  output logic            wrapOut
);
  // units roll at nine, tens carry
  always_comb begin
    wrapOut  = (valueIn >= maxVal);
    if (wrapOut) begin
      valueOut = minVal;
    end else if (valueIn[3:0] == 4'h9) begin
      valueOut = {valueIn[7:4] + 4'h1, 4'h0};
    end else begin
      valueOut = {valueIn[7:4], valueIn[3:0] + 4'h1};
    end
  end
endmodule : cbr_bcd_step
`default_nettype wire

// file: cbr_calendar_date.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbr_regs.svh"
// How it works
// [RL1] century 19-20 gregorian, 13-14 persian
// [RL2] fields bcd, units in low nibble
// [RL3] year holds bcd 00 to 99
// [RL4] month holds bcd 01 to 12
// [RL5] day of week holds 1 to 7
// [RL6] day of week never touches date
// [RL7] date holds bcd 01 to 31
// [RL8] software ignores reads in utc mode
// [RL9] date rolls month, year, century; weekday advances
// [RL10] writes load all fields; reads atomic
module cbr_calendar_date
  import cbr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        dayTick,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             utcMode
);

  //////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    cbr_cal_t    cal;       // calendar fields
    logic        persian;   // century range select
    logic        utc;       // utc mode flag
    logic        run;       // day counting enable
    logic        badWr;     // sticky: rejected write
    cbr_bus_t    bus;       // apb phase
    logic [31:0] rdata;     // read data
    logic        ready;     // answer strobe
    logic        err;       // answer error
  } cbr_state_t;

  cbr_state_t st_reg;
  cbr_state_t st_next;

  //////////////////////////////////////////////////////////////////////////
  // helpers
  // true when both nibbles are decimal digits [RL2]
  function automatic logic isBcd(input logic [7:0] v);
    isBcd = (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9);
  endfunction : isBcd

  // days in month in bcd, leap year by two-digit year only
  function automatic logic [7:0] monthLen(input logic [4:0] m,
                                          input logic [7:0] y);
    logic leap;
    leap = (y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                 : (y[3:0] == 4'h0 || y[3:0] == 4'h4 ||
                    y[3:0] == 4'h8));
    unique case (m)
      5'h02:   monthLen = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: monthLen = 8'h30;
      default: monthLen = `CBR_DATE_MAX;
    endcase
  endfunction : monthLen

  // pack a snapshot into the register word
  function automatic logic [31:0] packCal(input cbr_cal_t c);
    packCal = {2'b00, c.date, c.dow, c.month, c.year, c.century_field};
  endfunction : packCal

  //////////////////////////////////////////////////////////////////////////
  // incrementers
  logic [7:0] dateInc;   // next date value
  logic       dateWrap;  // date passed month end
  logic [7:0] monInc;    // next month value
  logic       monWrap;   // month passed december
  logic [7:0] yearInc;   // next year value
  logic       yearWrap;  // year passed 99
  logic [7:0] centInc;   // next century value
  logic [7:0] centMax;   // century upper bound
  logic [7:0] centMin;   // century lower bound

  // date rolls at month length [RL7] [RL9]
  cbr_bcd_step uDate (
    .valueIn  ({2'b00, st_reg.cal.date}),
    .maxVal   (monthLen(st_reg.cal.month, st_reg.cal.year)),
    .minVal   (8'h01),
    .valueOut (dateInc),
    .wrapOut  (dateWrap)
  );

  // month rolls after twelve [RL4] [RL9]
  cbr_bcd_step uMonth (
    .valueIn  ({3'b000, st_reg.cal.month}),
    .maxVal   (`CBR_MONTH_MAX),
    .minVal   (8'h01),
    .valueOut (monInc),
    .wrapOut  (monWrap)
  );

  // year rolls after 99 [RL3] [RL9]
  cbr_bcd_step uYear (
    .valueIn  (st_reg.cal.year),
    .maxVal   (`CBR_YEAR_MAX),
    .minVal   (8'h00),
    .valueOut (yearInc),
    .wrapOut  (yearWrap)
  );

  // century range by calendar mode [RL1]
  assign centMax = st_reg.persian ? `CBR_CENTURY_FIELD_PERS_HI : `CBR_CENTURY_FIELD_GREG_HI;
  assign centMin = st_reg.persian ? `CBR_CENTURY_FIELD_PERS_LO : `CBR_CENTURY_FIELD_GREG_LO;

  cbr_bcd_step uCent (
    .valueIn  (st_reg.cal.century_field),
    .maxVal   (centMax),
    .minVal   (centMin),
    .valueOut (centInc),
    .wrapOut  ()
  );

  //////////////////////////////////////////////////////////////////////////
  // write check
  cbr_cal_t wrCal;   // incoming calendar word
  logic     wrOk;    // every field in range

  always_comb begin
    wrCal = cbr_cal_t'({pwdata[29:24], pwdata[23:21], pwdata[20:16],
                        pwdata[15:8], pwdata[7:0]});
    // century window follows mode [RL1]
    wrOk = isBcd(wrCal.century_field) && isBcd(wrCal.year)              // [RL2]
        && (wrCal.century_field >= centMin) && (wrCal.century_field <= centMax)  // [RL1]
        && (wrCal.year <= `CBR_YEAR_MAX)                       // [RL3]
        && isBcd({3'b000, wrCal.month}) && (wrCal.month != 5'h00)
        && ({3'b000, wrCal.month} <= `CBR_MONTH_MAX)           // [RL4]
        && (wrCal.dow != 3'h0)                                 // [RL5]
        && isBcd({2'b00, wrCal.date}) && (wrCal.date != 6'h00)
        && ({2'b00, wrCal.date} <= `CBR_DATE_MAX)              // [RL7]
        && (pwdata[31:30] == 2'b00);
  end

  //////////////////////////////////////////////////////////////////////////
  // next state
  logic access;  // second apb cycle seen this edge

  always_comb begin
    st_next       = st_reg;
    st_next.ready = 1'b0;
    st_next.err   = 1'b0;
    access        = psel && penable && (st_reg.bus == CBR_ACCESS);

    // day counting, overridden when a valid calendar write lands this cycle
    if (dayTick && st_reg.run) begin
      // weekday steps on its own, never feeds the date [RL6] [RL9]
      st_next.cal.dow = (st_reg.cal.dow >= `CBR_DOW_MAX) ? 3'h1
                        : st_reg.cal.dow + 3'h1;
      st_next.cal.date = dateInc[5:0];                  // [RL9]
      if (dateWrap) begin
        st_next.cal.month = monInc[4:0];                // [RL9]
        if (monWrap) begin
          st_next.cal.year = yearInc;                   // [RL9]
          if (yearWrap) begin
            st_next.cal.century_field = centInc;                 // [RL9]
          end
        end
      end
    end

    // apb: setup then one-cycle access, answer with pready
    unique case (st_reg.bus)
      CBR_IDLE: begin
        if (psel && !penable) begin
          st_next.bus = CBR_ACCESS;
        end
      end
      CBR_ACCESS: begin
        st_next.bus = CBR_IDLE;
      end
    endcase

    if (access) begin
      st_next.ready = 1'b1;
      st_next.rdata = 32'h0000_0000;
      unique case (paddr)
        `CBR_ADDR_CAL: begin
          if (pwrite) begin
            // whole word loads at once, overriding the tick [RL10]
            if (wrOk) begin
              st_next.cal = wrCal;                      // [RL10]
            end else begin
              st_next.badWr = 1'b1;
              st_next.err   = 1'b1;
            end
          end else begin
            // snapshot from one register, never torn [RL10]
            st_next.rdata = packCal(st_reg.cal);        // [RL10]
          end
        end
        `CBR_ADDR_CTRL: begin
          if (pwrite) begin
            st_next.persian = pwdata[`CBR_CTRL_PERSIAN];
            st_next.utc     = pwdata[`CBR_CTRL_UTC];
            st_next.run     = pwdata[`CBR_CTRL_RUN];
          end else begin
            st_next.rdata[`CBR_CTRL_PERSIAN] = st_reg.persian;
            st_next.rdata[`CBR_CTRL_UTC]     = st_reg.utc;
            st_next.rdata[`CBR_CTRL_RUN]     = st_reg.run;
          end
        end
        `CBR_ADDR_STAT: begin
          // read returns then clears the rejected-write flag; writes here leave it alone
          if (!pwrite) begin
            st_next.rdata[`CBR_STAT_BADWR] = st_reg.badWr;
            st_next.badWr = 1'b0;
          end
        end
        default: begin
          st_next.err = 1'b1;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg         <= '0;
      st_reg.cal     <= cbr_cal_t'(`CBR_CAL_RESET);
      st_reg.run     <= 1'b1;
      st_reg.bus     <= CBR_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  // in utc mode the calendar word is kept but not meaningful [RL8]
  assign prdata  = st_reg.rdata;
  assign pready  = st_reg.ready;
  assign pslverr = st_reg.err;
  assign utcMode = st_reg.utc;

endmodule : cbr_calendar_date
`default_nettype wire

// file: cbr_calendar_date_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbr_regs.svh"
// protocol and field watcher on the apb side
module cbr_calendar_date_monitor (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        dayTick,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        utcMode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // good calendar read; utc reads carry no meaning, so skip them
  wire logic rdOk = pready && !pwrite && !pslverr && !utcMode &&
                    paddr == `CBR_ADDR_CAL;
  wire logic mapped = paddr inside {`CBR_ADDR_CAL, `CBR_ADDR_CTRL,
                                    `CBR_ADDR_STAT};
  property p_century_field; rdOk |-> prdata[7:0] inside {8'h13, 8'h14, 8'h19, 8'h20}; endproperty
  a_century_field: assert property (p_century_field) else $error("bad century");
  property p_year; rdOk |-> prdata[15:12] <= 4'h9 && prdata[11:8] <= 4'h9; endproperty
  a_year: assert property (p_year) else $error("bad year");
  property p_month; rdOk |-> prdata[20:16] inside {[5'h01:5'h09], [5'h10:5'h12]}; endproperty
  a_month: assert property (p_month) else $error("bad month");
  property p_dow; rdOk |-> prdata[23:21] != 3'h0; endproperty
  a_dow: assert property (p_dow) else $error("bad weekday");
  property p_date; rdOk |-> prdata[27:24] <= 4'h9 && prdata[31:24] inside {[8'h01:8'h31]}; endproperty
  a_date: assert property (p_date) else $error("bad date");
  property p_ready; psel && penable && !pready |=> pready ##1 !pready; endproperty
  a_ready: assert property (p_ready) else $error("late ready");
  property p_bad; pready && pwrite && paddr == `CBR_ADDR_CAL && pwdata[31:30] != 2'h0 |-> pslverr; endproperty
  a_bad: assert property (p_bad) else $error("bad write taken");
  property p_unmap; psel && !penable && !mapped |-> ##2 pslverr && prdata == 32'h0000_0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped answer");
  // main scenarios reached
  c_read: cover property (rdOk);
  c_err: cover property (pready && pslverr);
  c_tick: cover property (dayTick);
endmodule : cbr_calendar_date_monitor
bind cbr_calendar_date cbr_calendar_date_monitor i_cbr_calendar_date_monitor (
  .clk(clk), .rst_b(rst_b), .dayTick(dayTick), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .utcMode(utcMode));
`default_nettype wire

// file: cbr_calendar_date_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "cbr_regs.svh"
module cbr_calendar_date_test;
  logic        clk = 0, rst_b = 0, dayTick = 0, err;
  logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, utcMode;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  int          numErrors = 0, cmpCount = 0;
  always #12.5 clk = ~clk;
  cbr_calendar_date i_cbr_calendar_date (.clk(clk), .rst_b(rst_b),
    .dayTick(dayTick), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .utcMode(utcMode));
  ////////////////////////////////////////////////////////////////////////////
  // one apb transfer, request held until pready is seen
  task automatic apb(input logic w, input logic [31:0] a, d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) numErrors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] g, e);
    cmpCount++;
    if (g !== e) begin
      numErrors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    apb(0, `CBR_ADDR_CAL, 0);
    chk(rd, `CBR_CAL_RESET);
    $display("reset test done");
  endtask : t_reset
  // edge values kept, every out of range field refused whole
  task automatic t_bounds;
    logic [31:0] bad [10] = '{32'h31F3_9920, 32'h3112_9920, 32'h32F2_9920,
      32'h31F2_9A20, 32'h31F2_9921, 32'h31F2_9913, 32'hF1F2_9920,
      32'h31E0_9920, 32'h00F2_9920, 32'h31F2_9918};
    apb(1, `CBR_ADDR_CAL, 32'h31F2_9920);
    chk(32'(err), 0);
    foreach (bad[i]) begin
      apb(1, `CBR_ADDR_CAL, bad[i]);
      chk(32'(err), 1);
      apb(0, `CBR_ADDR_CAL, 0);
      chk(rd, 32'h31F2_9920);
    end
    apb(0, `CBR_ADDR_STAT, 0);
    chk(rd, 1);
    $display("bounds test done");
  endtask : t_bounds
  // century, month and weekday wraps; weekday 7 goes to 1, weekday 3 goes to 4
  task automatic t_roll;
    logic [31:0] st [3] = '{32'h31F2_9920, 32'h31E1_2420, 32'h3064_2420};
    logic [31:0] nx [3] = '{32'h0121_0019, 32'h0122_2420, 32'h0185_2420};
    foreach (st[i]) begin
      apb(1, `CBR_ADDR_CAL, st[i]);
      @(posedge clk);
      dayTick <= 1'b1;
      @(posedge clk);
      dayTick <= 1'b0;
      apb(0, `CBR_ADDR_CAL, 0);
      chk(rd, nx[i]);
    end
    $display("rollover test done");
  endtask : t_roll
  // persian century range, unmapped place, utc flag
  task automatic t_modes;
    apb(1, `CBR_ADDR_CTRL, 32'h0000_0005);
    apb(1, `CBR_ADDR_CAL, 32'h0121_0013);
    chk(32'(err), 0);
    apb(1, `CBR_ADDR_CAL, 32'h0121_0020);
    chk(32'(err), 1);
    apb(1, `CBR_ADDR_CTRL, 32'h0000_0006);
    apb(0, 32'hF804_80D0, 0);
    chk({rd[30:0], err}, 1);
    chk(32'(utcMode), 1);
    $display("mode test done");
  endtask : t_modes
  // one day pulse, held for a single clock
  task automatic day_pulse;
    @(posedge clk);
    dayTick <= 1'b1;
    @(posedge clk);
    dayTick <= 1'b0;
  endtask : day_pulse
  // leap february, run bit off, status clear on read
  task automatic t_more;
    apb(1, `CBR_ADDR_CTRL, 32'h0000_0004);
    apb(0, `CBR_ADDR_STAT, 0);
    chk(rd, 1);
    apb(0, `CBR_ADDR_STAT, 0);
    chk(rd, 0);
    apb(1, `CBR_ADDR_CAL, 32'h2822_2420);
    day_pulse();
    apb(0, `CBR_ADDR_CAL, 0);
    chk(rd, 32'h2942_2420);
    day_pulse();
    apb(0, `CBR_ADDR_CAL, 0);
    chk(rd, 32'h0163_2420);
    apb(1, `CBR_ADDR_CAL, 32'h2822_2320);
    day_pulse();
    apb(0, `CBR_ADDR_CAL, 0);
    chk(rd, 32'h0143_2320);
    // counting stopped: a pulse must leave the word alone
    apb(1, `CBR_ADDR_CTRL, 32'h0000_0000);
    day_pulse();
    apb(0, `CBR_ADDR_CAL, 0);
    chk(rd, 32'h0143_2320);
    $display("leap and run test done");
  endtask : t_more
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_bounds();
    t_roll();
    t_modes();
    t_more();
    finish_test();
  end
  // tests need a few hundred cycles; 4000 means a hang
  initial begin
    #100000;
    numErrors++;
    finish_test();
  end
endmodule : cbr_calendar_date_test
`default_nettype wire
